// file: verilog/eeh_ctrl.sv
// Purpose: apb-programmed host that drives a byte-wide parallel eeprom
// Assumes: one 10 MHz clock, pins synchronised here, device timing in pkg
// Notes:   ops: 1 read, 2 byte, 3 page, 4 erase, 5 lock on, 6 lock off
`timescale 1ns/1ps
module eeh_ctrl #(
   parameter int WR_CYCLES    = eeh_pkg::WR_CYCLE_CYC,
   parameter int ERASE_CYCLES = eeh_pkg::ERASE_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // eeprom pins
   output logic      [10:0] addressLines,
   output logic      [7:0]  dataLinesOut,
   output logic             dataLinesOe,
   input  wire logic [7:0]  dataLinesIn,
   output logic             chipSelectN,
   output logic             outputEnableN,
   output logic             writeStrobeN,
   output logic             eraseLevelEn,
   input  wire logic        completionPin
);
   import eeh_pkg::*;

   localparam logic [19:0] SETUP_END = 20'(SETUP_CYC - 1);
   localparam logic [19:0] PULSE_END = 20'(WR_PULSE_CYC - 1);
   localparam logic [19:0] READ_WAIT = 20'(ACCESS_CYC + SYNC_CYC);
   localparam logic [19:0] GAP_END   = 20'(POLL_GAP_CYC - 1);
   localparam logic [19:0] ER_LEN    = 20'(ERASE_CYCLES);
   localparam logic [19:0] ER_LOW    = 20'(ERASE_CYCLES);
   localparam logic [19:0] ER_END    = 20'(ERASE_CYCLES + 2);
   localparam logic [19:0] SETTLE    = 20'(2 * PAGE_WIN_CYC);
   localparam logic [19:0] WR_LIM    = 20'(WR_CYCLES + PAGE_WIN_CYC);
   localparam logic [19:0] ER_LIM    = 20'(ERASE_CYCLES + WR_CYCLES);

   typedef struct packed {
      eeh_state_e  st;
      eeh_op_e     op;
      logic        tog;
      logic [19:0] cnt;
      logic [19:0] wcnt;
      logic [6:0]  idx;
      logic [6:0]  len;
      logic        busySeen;
      logic        prevTog;
      logic        togValid;
      logic [10:0] aReg;
      logic [7:0]  dReg;
      logic [7:0]  rData;
      logic [6:0]  pCnt;
      logic        done;
      logic        tmo;
      logic [10:0] addr;
      logic [7:0]  dout;
      logic        doe;
      logic        csN;
      logic        oeN;
      logic        weN;
      logic        erase;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [7:0]  d1;
      logic [7:0]  d2;
      logic [7:0]  d3;
      logic [2:0]  c;
      logic        memWe;
      logic [5:0]  memWa;
      logic [7:0]  memWd;
      logic [6:0]  nStb;
      logic [19:0] lowLen;
   } eeh_ctrl_s;

   eeh_ctrl_s   s_r;
   eeh_ctrl_s   s_nxt;
   logic [7:0]  memRd;
   logic [10:0] srcA;
   logic [7:0]  srcD;
   logic        pinHigh;
   logic        pinLow;
   logic        busy;
   logic        moreBytes;
   logic        finish;
   logic [19:0] lim;

   eeh_page_mem #(.DEPTH(PAGE_BYTES), .WIDTH(DATA_W), .AW(PAGE_IDX_W)) u_mem (
      .clk (ref_clk),
      .we  (s_r.memWe),
      .wa  (s_r.memWa),
      .wd  (s_r.memWd),
      .ra  (s_r.idx[5:0]),
      .rd  (memRd)
   );

   always_comb begin
      s_nxt = s_r;
      // a pin level counts once the second and third stages agree
      s_nxt.d1 = dataLinesIn;
      s_nxt.d2 = s_r.d1;
      s_nxt.d3 = s_r.d2;
      s_nxt.c = {s_r.c[1:0], completionPin};
      pinHigh = s_r.c[1] & s_r.c[2];
      pinLow = ~s_r.c[1] & ~s_r.c[2];
      busy = (s_r.st != ST_IDLE);
      moreBytes = (s_r.idx + 7'd1) < s_r.len;
      lim = (s_r.op == OP_ERASE) ? ER_LIM : WR_LIM;
      finish = 1'b0;
      s_nxt.memWe = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      case (s_r.op)
         OP_PAGE: begin
            srcA = {s_r.aReg[10:PAGE_MSB_POS], s_r.idx[5:0]};
            srcD = memRd;
         end
         OP_LOCK_ON, OP_LOCK_OFF: begin
            {srcA, srcD} = lock_entry(s_r.op == OP_LOCK_OFF,
                                      s_r.idx[2:0]);
         end
         default: begin
            srcA = s_r.aReg;
            srcD = s_r.dReg;
         end
      endcase
      // apb: answer a cycle after access starts so prdata is registered
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         case (paddr)
            REG_CTRL: s_nxt.prdata = {28'h000_0000, s_r.tog, s_r.op};
            REG_ADDR: s_nxt.prdata = {21'h00_0000, s_r.aReg};
            REG_DATA: s_nxt.prdata = {24'h00_0000, s_r.dReg};
            REG_PAGE: s_nxt.prdata = {25'h000_0000, s_r.pCnt};
            REG_STAT: s_nxt.prdata = {16'h0000, s_r.rData, 4'h0, pinHigh,
                                      s_r.tmo, s_r.done, busy};
            default:  s_nxt.prdata = 32'h0000_0000;
         endcase
         // page contents and address must not move under a running op
         if (pwrite) begin
            s_nxt.pslverr = (paddr == REG_STAT) || busy
                            || !(paddr inside {REG_CTRL, REG_ADDR,
                                               REG_DATA, REG_PAGE})
                            || (paddr == REG_PAGE && s_r.pCnt[6]);
         end else begin
            s_nxt.pslverr = !(paddr inside {REG_CTRL, REG_ADDR, REG_DATA,
                                            REG_PAGE, REG_STAT});
         end
      end
      if (psel && penable && pwrite && s_r.pready && !s_r.pslverr) begin
         case (paddr)
            REG_ADDR: s_nxt.aReg = pwdata[10:0];
            REG_DATA: s_nxt.dReg = pwdata[7:0];
            REG_PAGE: begin
               s_nxt.memWe = 1'b1;
               s_nxt.memWa = s_r.pCnt[5:0];
               s_nxt.memWd = pwdata[7:0];
               s_nxt.pCnt = s_r.pCnt + 7'd1;
            end
            default: begin
               s_nxt.tog = pwdata[CTRL_TOG_POS];
               s_nxt.idx = 7'd0;
               s_nxt.cnt = 20'd0;
               s_nxt.done = 1'b0;
               s_nxt.tmo = 1'b0;
               s_nxt.op = eeh_op_e'(pwdata[2:0]);
               case (pwdata[2:0])
                  3'd1: begin
                     s_nxt.st = ST_POLL;
                     s_nxt.addr = s_r.aReg;
                     s_nxt.csN = 1'b0;
                     s_nxt.oeN = 1'b0;
                  end
                  3'd2: begin
                     s_nxt.st = ST_SETUP;
                     s_nxt.len = 7'd1;
                  end
                  3'd3: begin
                     s_nxt.len = s_r.pCnt;
                     s_nxt.st = (s_r.pCnt == 7'd0) ? ST_IDLE : ST_SETUP;
                     s_nxt.done = (s_r.pCnt == 7'd0);
                  end
                  3'd4: begin
                     s_nxt.st = ST_ERASE;
                     s_nxt.csN = 1'b0;
                     s_nxt.erase = 1'b1;
                     s_nxt.oeN = 1'b1;
                  end
                  3'd5: begin
                     s_nxt.st = ST_SETUP;
                     s_nxt.len = LOCK_ON_LEN;
                  end
                  3'd6: begin
                     s_nxt.st = ST_SETUP;
                     s_nxt.len = LOCK_OFF_LEN;
                  end
                  default: s_nxt.op = s_r.op;
               endcase
            end
         endcase
      end
      case (s_r.st)
         ST_SETUP: begin
            s_nxt.cnt = s_r.cnt + 20'd1;
            s_nxt.addr = srcA;
            s_nxt.csN = 1'b0;
            s_nxt.oeN = 1'b1;
            if (s_r.cnt == SETUP_END) begin
               s_nxt.st = ST_STROBE;
               s_nxt.dout = srcD;
               s_nxt.doe = 1'b1;
               s_nxt.weN = 1'b0;
               s_nxt.cnt = 20'd0;
            end
         end
         ST_STROBE: begin
            s_nxt.cnt = s_r.cnt + 20'd1;
            if (s_r.cnt == PULSE_END) begin
               s_nxt.weN = 1'b1;
               s_nxt.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // next byte follows in a few cycles, far inside the load window
            s_nxt.doe = 1'b0;
            s_nxt.csN = 1'b1;
            s_nxt.idx = s_r.idx + 7'd1;
            s_nxt.cnt = 20'd0;
            s_nxt.st = moreBytes ? ST_SETUP : ST_WAITB;
            s_nxt.wcnt = 20'd0;
            s_nxt.busySeen = 1'b0;
            s_nxt.togValid = 1'b0;
         end
         ST_ERASE: begin
            s_nxt.cnt = s_r.cnt + 20'd1;
            if (s_r.cnt == 20'd0) begin
               s_nxt.weN = 1'b0;
            end
            if (s_r.cnt == ER_LOW) begin
               s_nxt.weN = 1'b1;
            end
            if (s_r.cnt == ER_END) begin
               s_nxt.csN = 1'b1;
               s_nxt.erase = 1'b0;
               s_nxt.st = ST_WAITB;
               s_nxt.cnt = 20'd0;
               s_nxt.wcnt = 20'd0;
               s_nxt.busySeen = 1'b0;
               s_nxt.togValid = 1'b0;
            end
         end
         ST_WAITB: begin
            s_nxt.wcnt = s_r.wcnt + 20'd1;
            s_nxt.cnt = s_r.cnt + 20'd1;
            if (pinLow) begin
               s_nxt.busySeen = 1'b1;
            end
            // a locked device never goes busy, so settle also ends the wait
            if (!s_r.tog && pinHigh
                && (s_r.busySeen || s_r.wcnt >= SETTLE)) begin
               finish = 1'b1;
            end else if (s_r.tog && s_r.cnt == GAP_END) begin
               s_nxt.st = ST_POLL;
               s_nxt.cnt = 20'd0;
               s_nxt.csN = 1'b0;
               s_nxt.oeN = 1'b0;
            end
         end
         ST_POLL: begin
            s_nxt.cnt = s_r.cnt + 20'd1;
            s_nxt.wcnt = s_r.wcnt + 20'd1;
            if (s_r.cnt >= READ_WAIT && s_r.d2 == s_r.d3) begin
               s_nxt.rData = s_r.d3;
               s_nxt.csN = 1'b1;
               s_nxt.oeN = 1'b1;
               s_nxt.cnt = 20'd0;
               s_nxt.prevTog = s_r.d3[TOGGLE_POS];
               s_nxt.togValid = 1'b1;
               if (s_r.op == OP_READ) begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.done = 1'b1;
               end else if (s_r.togValid && s_r.wcnt >= SETTLE
                            && s_r.prevTog == s_r.d3[TOGGLE_POS]) begin
                  finish = 1'b1;
               end else begin
                  s_nxt.st = ST_WAITB;
               end
            end
         end
         default: begin
         end
      endcase
      // a wait that outlives the longest device cycle ends with an error
      if ((s_r.st == ST_WAITB || s_r.st == ST_POLL) && s_r.op != OP_READ
          && s_r.wcnt == lim && !finish) begin
         s_nxt.tmo = 1'b1;
         finish = 1'b1;
      end
      if (finish) begin
         s_nxt.st = ST_IDLE;
         s_nxt.done = 1'b1;
         s_nxt.csN = 1'b1;
         s_nxt.oeN = 1'b1;
         if (s_r.op == OP_PAGE) begin
            s_nxt.pCnt = 7'd0;
         end
      end
      s_nxt.nStb = (s_r.st == ST_IDLE) ? 7'd0
                 : (s_r.weN && !s_nxt.weN) ? s_r.nStb + 7'd1 : s_r.nStb;
      s_nxt.lowLen = s_r.weN ? 20'd0 : s_r.lowLen + 20'd1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.csN <= 1'b1;
         s_r.oeN <= 1'b1;
         s_r.weN <= 1'b1;
         s_r.c <= 3'b111;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata        = s_r.prdata;
   assign pready        = s_r.pready;
   assign pslverr       = s_r.pslverr;
   assign addressLines  = s_r.addr;
   assign dataLinesOut  = s_r.dout;
   assign dataLinesOe   = s_r.doe;
   assign chipSelectN   = s_r.csN;
   assign outputEnableN = s_r.oeN;
   assign writeStrobeN  = s_r.weN;
   assign eraseLevelEn  = s_r.erase;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   write_start_a: assert property (
      !writeStrobeN && !chipSelectN |-> outputEnableN)
      else $error("write strobe low while output enable low");
   drive_oe_a: assert property (
      dataLinesOe |-> outputEnableN && !chipSelectN)
      else $error("data driven while device may drive");
   page_upper_a: assert property (
      s_r.st == ST_STROBE && s_r.op == OP_PAGE
      |-> addressLines[10:6] == s_r.aReg[10:6] && $stable(s_r.aReg))
      else $error("page upper address moved");
   page_gap_a: assert property (
      s_r.st == ST_HOLD && moreBytes |-> ##[1:8] $fell(writeStrobeN))
      else $error("next page byte late");
   erase_pulse_a: assert property (
      $rose(writeStrobeN) && eraseLevelEn
      |-> s_r.lowLen == ER_LEN && !chipSelectN)
      else $error("erase strobe length wrong");
   lock_bytes_a: assert property (
      s_r.st == ST_STROBE && s_r.op inside {OP_LOCK_ON, OP_LOCK_OFF}
      |-> {addressLines, dataLinesOut}
          == lock_entry(s_r.op == OP_LOCK_OFF, s_r.idx[2:0]))
      else $error("lock sequence byte wrong");
   lock_on_len_a: assert property (
      s_r.st == ST_WAITB && $past(s_r.st) == ST_HOLD
      && s_r.op == OP_LOCK_ON |-> s_r.nStb == LOCK_ON_LEN)
      else $error("lock enable strobe count wrong");
   lock_off_len_a: assert property (
      s_r.st == ST_WAITB && $past(s_r.st) == ST_HOLD
      && s_r.op == OP_LOCK_OFF |-> s_r.nStb == LOCK_OFF_LEN)
      else $error("lock release strobe count wrong");
   apb_answer_a: assert property (
      psel && penable && !pready |=> pready)
      else $error("apb answer late");

   read_done_c: cover property (
      s_r.st == ST_POLL && s_r.op == OP_READ ##1 s_r.st == ST_IDLE);
   page_done_c: cover property (
      s_r.op == OP_PAGE && s_r.st == ST_WAITB ##1 s_r.st == ST_IDLE);
   erase_run_c: cover property ($rose(writeStrobeN) && eraseLevelEn);
   lock_off_c: cover property (
      s_r.op == OP_LOCK_OFF && s_r.st == ST_HOLD && !moreBytes);
endmodule

// file: pkg/eeh_pkg.sv
// Purpose: shared constants and types for the byte-wide eeprom host controller
// Assumes: 10 MHz ref_clk, eeprom of 2K bytes with 64-byte pages
// Notes:   times are kept in their own unit; cycle counts derive from them, except setup, sync and poll gap, given in cycles
package eeh_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACCESS_NS     = 150;
   localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int WR_PULSE_NS   = 100;
   localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int WR_CYCLE_MS   = 3;
   localparam int WR_CYCLE_CYC  = WR_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int ERASE_MS      = 10;
   localparam int ERASE_CYC     = ERASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PAGE_WIN_US   = 100;
   localparam int PAGE_WIN_CYC  = PAGE_WIN_US * 1000 / CLK_PERIOD_NS;
   localparam int SETUP_CYC     = 2;
   localparam int SYNC_CYC      = 3;
   localparam int POLL_GAP_CYC  = 2;
   // array geometry
   localparam int ADDR_W        = 11;
   localparam int DATA_W        = 8;
   localparam int PAGE_BYTES    = 64;
   localparam int PAGE_IDX_W    = 6;
   localparam int PAGE_MSB_POS  = 6;
   // status bits on the data lines
   localparam int POLL_POS      = 7;
   localparam int TOGGLE_POS    = 6;
   localparam int TIMER_POS     = 5;
   // register offsets
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_ADDR = 12'h004;
   localparam logic [11:0] REG_DATA = 12'h008;
   localparam logic [11:0] REG_PAGE = 12'h00C;
   localparam logic [11:0] REG_STAT = 12'h010;
   // field positions
   localparam int CTRL_TOG_POS  = 3;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_DONE_POS = 1;
   localparam int STAT_TMO_POS  = 2;
   localparam int STAT_PIN_POS  = 3;
   localparam int STAT_RD_POS   = 8;
   // write lock sequences
   localparam logic [10:0] LOCK_ADDR_A   = 11'h555;
   localparam logic [10:0] LOCK_ADDR_B   = 11'h2AA;
   localparam logic [7:0]  LOCK_KEY_1    = 8'hAA;
   localparam logic [7:0]  LOCK_KEY_2    = 8'h55;
   localparam logic [7:0]  LOCK_ON_CMD   = 8'hA0;
   localparam logic [7:0]  LOCK_OFF_CMD1 = 8'h80;
   localparam logic [7:0]  LOCK_OFF_CMD2 = 8'h20;
   localparam logic [6:0]  LOCK_ON_LEN   = 7'd3;
   localparam logic [6:0]  LOCK_OFF_LEN  = 7'd6;

   typedef enum logic [2:0] {
      OP_NONE, OP_READ, OP_BYTE, OP_PAGE, OP_ERASE, OP_LOCK_ON, OP_LOCK_OFF
   } eeh_op_e;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b010,
      ST_WAITB  = 3'b110,
      ST_POLL   = 3'b111,
      ST_ERASE  = 3'b100
   } eeh_state_e;

   // address and data of step i of a lock sequence, address in the top bits
   function automatic logic [18:0] lock_entry(input logic off,
                                              input logic [2:0] i);
      logic [18:0] r;
      case (i)
         3'd0, 3'd3: r = {LOCK_ADDR_A, LOCK_KEY_1};
         3'd1, 3'd4: r = {LOCK_ADDR_B, LOCK_KEY_2};
         3'd2:       r = {LOCK_ADDR_A, off ? LOCK_OFF_CMD1 : LOCK_ON_CMD};
         default:    r = {LOCK_ADDR_A, LOCK_OFF_CMD2};
      endcase
      return r;
   endfunction
endpackage

// file: verilog/eeh_page_mem.sv
// Purpose: page staging buffer, one write port and a registered read port
// Assumes: single clock, read data valid one edge after the read address
// Notes:   contents are data only and carry no reset
`timescale 1ns/1ps
module eeh_page_mem #(
   parameter int DEPTH = 64,
   parameter int WIDTH = 8,
   parameter int AW    = 6
) (
   // clock
   input  wire logic             clk,
   // write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    wa,
   input  wire logic [WIDTH-1:0] wd,
   // read port
   input  wire logic [AW-1:0]    ra,
   output logic      [WIDTH-1:0] rd
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wa] <= wd;
      end
      rd <= mem[ra];
   end
endmodule

// file: testbench/eeh_eeprom_model.sv
// Purpose: behavioural byte-wide eeprom on the far side of the host
// Assumes: pins sampled on ref_clk, timers counted in its cycles
// Notes:   lock state has no reset; loose bus shows a moving pattern
`timescale 1ns/1ps
module eeh_eeprom_model #(
   parameter int PROG_CYC  = 100,
   parameter int WIN_CYC   = 20,
   parameter int ERASE_MIN = 40
) (
   // timer clock
   input  wire logic        ref_clk,
   // host pins
   input  wire logic [10:0] addressLines,
   input  wire logic [7:0]  dataLinesOut,
   input  wire logic        dataLinesOe,
   input  wire logic        chipSelectN,
   input  wire logic        outputEnableN,
   input  wire logic        writeStrobeN,
   input  wire logic        eraseLevelEn,
   // supply monitor, high blocks every write
   input  wire logic        supplyLow,
   // device outputs
   output logic      [7:0]  dataLinesIn,
   output logic             completionPin
);
   import eeh_pkg::*;
   logic [7:0]  mem [0:2047];
   logic        locked = 1'b0; // no reset, so it outlives a host reset
   logic [113:0] hist = '0; // last six captured address and data pairs
   logic [10:0] wAddr = 11'h000;
   logic [7:0]  lastD = 8'h00;
   logic [7:0]  junk  = 8'h00;
   logic        wrQ = 1'b0, rdQ = 1'b0, loading = 1'b0;
   logic        busy = 1'b0, tog = 1'b0;
   int          tmr = 0, eraseLen = 0;
   wire wrAct = !chipSelectN && !writeStrobeN && outputEnableN
                && !eraseLevelEn && !supplyLow;
   wire [18:0]  cap    = {wAddr, dataLinesOut};
   wire [56:0]  onSeq  = {LOCK_ADDR_A, LOCK_KEY_1, LOCK_ADDR_B, LOCK_KEY_2,
                          LOCK_ADDR_A, LOCK_ON_CMD};
   wire [113:0] offSeq = {onSeq[56:8], LOCK_OFF_CMD1,
                          onSeq[56:8], LOCK_OFF_CMD2};
   wire rdAct = !chipSelectN && !outputEnableN && writeStrobeN;
   wire [7:0] stat = {~lastD[7], tog, !loading, 5'h00};
   // a released bus must never look like the last value
   assign dataLinesIn = dataLinesOe ? dataLinesOut : !rdAct ? junk
                      : (busy || loading) ? stat : mem[addressLines];
   assign completionPin = !busy;
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
   always @(posedge ref_clk) begin
      junk <= junk + 8'h01;
      wrQ  <= wrAct;
      rdQ  <= rdAct;
      if (wrAct && !wrQ) wAddr <= addressLines;
      if (!wrAct && wrQ && !busy) begin
         hist <= {hist[94:0], cap}; // upper bits may differ here
         if ({hist[37:0], cap} == onSeq) locked <= 1'b1;
         if ({hist[94:0], cap} == offSeq) locked <= 1'b0;
         if (!locked) begin
            mem[wAddr] <= dataLinesOut;
            lastD      <= dataLinesOut;
            loading    <= 1'b1;
            tmr        <= 0;
         end
      end else if (loading && tmr >= WIN_CYC) begin
         loading <= 1'b0;
         busy    <= 1'b1;
         tog     <= 1'b0;
         tmr     <= 0;
      end else if (busy && tmr >= PROG_CYC) begin
         busy <= 1'b0;
      end else begin
         tmr <= tmr + 1;
      end
      if (!rdAct && rdQ && busy) tog <= !tog;
      if (eraseLevelEn && !chipSelectN && !writeStrobeN && !supplyLow) begin
         eraseLen <= eraseLen + 1;
      end else if (eraseLen >= ERASE_MIN && !locked) begin
         for (int i = 0; i < 2048; i++) mem[i] <= 8'hFF;
         lastD    <= 8'hFF;
         eraseLen <= 0;
         busy     <= 1'b1;
         tmr      <= 0;
      end else begin
         eraseLen <= 0;
      end
   end
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the eeprom host controller
// Assumes: shortened write and erase counts, model timers in cycles
// Notes:   rows do write and read back; page, erase, lock, supply, reset follow
`timescale 1ns/1ps
module tb_top;
   import eeh_pkg::*;
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  data;
      logic        togMode;
      logic [15:0] expRead;
   } eeh_row_s;
   logic        ref_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q, stat;
   logic        pready, pslverr, e;
   logic [10:0] addressLines;
   logic [7:0]  dataLinesOut, dataLinesIn;
   logic        dataLinesOe, chipSelectN, outputEnableN, writeStrobeN;
   logic        eraseLevelEn, completionPin;
   logic        supplyLow = 1'b0;
   int          fails = 0, comparisons = 0;
   eeh_row_s    rows [3] = '{'{11'h000, 8'hA5, 1'b0, 16'hA50A},
                             '{11'h7FF, 8'h3C, 1'b1, 16'h3C0A},
                             '{11'h045, 8'h80, 1'b0, 16'h800A}};
   always #50 ref_clk = ~ref_clk;
   eeh_ctrl #(.WR_CYCLES(3000), .ERASE_CYCLES(50)) eeh_ctrl_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .addressLines(addressLines),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
      .dataLinesIn(dataLinesIn), .chipSelectN(chipSelectN),
      .outputEnableN(outputEnableN), .writeStrobeN(writeStrobeN),
      .eraseLevelEn(eraseLevelEn), .completionPin(completionPin));
   eeh_eeprom_model eeh_eeprom_model_inst (
      .ref_clk(ref_clk), .addressLines(addressLines),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
      .chipSelectN(chipSelectN), .outputEnableN(outputEnableN),
      .writeStrobeN(writeStrobeN), .eraseLevelEn(eraseLevelEn),
      .dataLinesIn(dataLinesIn), .completionPin(completionPin),
      .supplyLow(supplyLow));
   task automatic summarize;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // poll status; a hung op that leaves busy set adds a fail without a comparison or message
   task automatic waitDone;
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0000_0000);
         n++;
      end while (q[STAT_BUSY_POS] !== 1'b0 && n < 3000);
      if (q[STAT_BUSY_POS] !== 1'b0) fails++;
      stat = q;
   endtask
   task automatic op(input logic [10:0] a, input logic [7:0] d,
                     input logic [3:0] c);
      apb(1'b1, REG_ADDR, {21'h00_0000, a});
      apb(1'b1, REG_DATA, {24'h00_0000, d});
      apb(1'b1, REG_CTRL, {28'h000_0000, c});
      waitDone;
   endtask
   always @(posedge ref_clk) begin
      if (rst_b && !writeStrobeN && !chipSelectN && !eraseLevelEn
          && !(outputEnableN && dataLinesOe)) begin
         fails++;
         $display("MISMATCH t=%0t oe=%h drv=%h", $time, outputEnableN,
                  dataLinesOe);
      end
   end
   initial begin
      #8000000;
      fails++;
      summarize;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         op(rows[i].addr, rows[i].data, {rows[i].togMode, 3'h2});
         chk(stat & 32'h0000_000F, 32'h0000_000A);
         op(rows[i].addr, 8'h00, 4'h1);
         chk(stat & 32'h0000_FFFF, {16'h0000, rows[i].expRead});
         $display("row %0d finished", i);
      end
      apb(1'b1, REG_CTRL, 32'h0000_0002);
      apb(1'b1, REG_CTRL, 32'h0000_0002);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      waitDone;
      apb(1'b1, REG_STAT, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      $display("refusal test finished");
      apb(1'b1, REG_ADDR, 32'h0000_00C0);
      for (int k = 0; k < 64; k++)
         apb(1'b1, REG_PAGE, {24'h00_0000, 8'(k) ^ 8'h5A});
      apb(1'b1, REG_PAGE, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b0, REG_PAGE, 32'h0000_0000);
      chk(q, 32'h0000_0040);
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      waitDone;
      chk(stat & 32'h0000_0007, 32'h0000_0002);
      for (int k = 0; k < 64; k += 21) begin
         op(11'h0C0 + 11'(k), 8'h00, 4'h1);
         chk(stat & 32'h0000_FF00, {16'h0000, 8'(k) ^ 8'h5A, 8'h00});
      end
      $display("page test finished");
      op(11'h7FF, 8'h00, 4'h4);
      chk(stat & 32'h0000_0007, 32'h0000_0002);
      op(11'h7FF, 8'h00, 4'h1);
      chk(stat & 32'h0000_FF00, 32'h0000_FF00);
      $display("erase test finished");
      op(11'h000, 8'h00, 4'h5);
      op(11'h000, 8'h11, 4'h2);
      chk(stat & 32'h0000_0007, 32'h0000_0002);
      op(11'h000, 8'h00, 4'h1);
      chk(stat & 32'h0000_FF00, 32'h0000_FF00);
      op(11'h000, 8'h00, 4'h6);
      op(11'h000, 8'h11, 4'h2);
      op(11'h000, 8'h00, 4'h1);
      chk(stat & 32'h0000_FF00, 32'h0000_1100);
      supplyLow <= 1'b1;
      op(11'h000, 8'h22, 4'h2);
      supplyLow <= 1'b0;
      op(11'h000, 8'h00, 4'h1);
      chk(stat & 32'h0000_FF00, 32'h0000_1100);
      $display("lock and supply test finished");
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({29'h0000_0000, chipSelectN, writeStrobeN, dataLinesOe},
          32'h0000_0006);
      rst_b <= 1'b1;
      apb(1'b0, REG_STAT, 32'h0000_0000);
      chk(q & 32'h0000_0007, 32'h0000_0000);
      $display("reset test finished");
      summarize;
   end
endmodule
